// >>> include/lrx_defines.svh
// Register offsets, field positions, reset values and timing for lrx
`ifndef LRX_DEFINES_SVH
`define LRX_DEFINES_SVH

// Register port geometry
`define LRX_ADDR_W        8
`define LRX_DATA_W        32

// Register offsets (byte addresses)
`define LRX_OFF_CTRL      8'h00
`define LRX_OFF_STATUS    8'h04
`define LRX_OFF_MASK      8'h08
`define LRX_OFF_EFFECT    8'h0c

// Control register fields (used in host mode only)
`define LRX_CTRL_RX_EN    0
`define LRX_CTRL_EQ_EN    1
`define LRX_CTRL_CLK_INV  2
`define LRX_CTRL_SINGLE   3
`define LRX_CTRL_W        4
`define LRX_CTRL_RESET    4'h1

// Status and mask fields
`define LRX_EVT_POS       0
`define LRX_EVT_NEG       1
`define LRX_EVT_VIOL      2
`define LRX_EVT_W         3
`define LRX_MASK_RESET    3'h0

// Effective-setting readback width
`define LRX_EFF_W         8

// Timing of the clocks involved
`define LRX_REF_PERIOD_NS 50
`define LRX_LINK_PERIOD_NS 400
`define LRX_SYNC_STAGES   2

`endif

// >>> include/lrx_pkg.sv
// Types shared by the lrx receive output and strap control block
package lrx_pkg;

	// Line rate selection, Gray coded
	typedef enum logic [1:0] {
		LRX_RATE_E3   = 2'h0,
		LRX_RATE_DS3  = 2'h1,
		LRX_RATE_STS1 = 2'h3
	} lrx_rate_t;

	// All pin inputs that cross into the reference clock domain
	typedef struct packed {
		logic       host;      // Host (1) or hardware (0) pin functions
		logic [1:0] rate;      // Line rate straps
		logic       bypass;    // Build-out bypass strap
		logic       rx_on;     // Receiver on, or host serial data in
		logic       eq;        // Equalizer enable strap
		logic       inv;       // Clock invert, or host chip select
		logic       single;    // Single rail strap
		logic       lclk;      // Recovered line clock
		logic       pos;       // Positive pulse detected
		logic       neg;       // Negative pulse detected
		logic       viol;      // Line code violation detected
	} lrx_pins_t;

	// Effective receive configuration after mode muxing
	typedef struct packed {
		logic rx_en;
		logic eq_en;
		logic clk_inv;
		logic single;
	} lrx_cfg_t;

endpackage : lrx_pkg

// >>> hw/lrx_sync.sv
// Two-flop synchroniser for the pin inputs of lrx
`timescale 1ns/1ps
module lrx_sync #(
	parameter int W = 12
) (
	input  wire logic         clk,  // Reference clock
	input  wire logic [W-1:0] d,    // Asynchronous pin levels
	output logic      [W-1:0] q     // Synchronised levels
);

	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	// Plain shift; no reset so straps settle while reset is held
	always_comb begin
		next_meta = d;
		next_q    = meta;
	end

	// First stage feeds only the second stage
	always_ff @(posedge clk) begin
		meta <= next_meta;
		q    <= next_q;
	end

endmodule : lrx_sync

// >>> hw/lrx_rx_port.sv
// Receive output port and pin-strap control of the line interface
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "lrx_defines.svh"

////////////////////////////////////////////////////////////////////////////
module lrx_rx_port
	import lrx_pkg::*;
(
	input  wire logic                   REF_CLK,        // 20 MHz clock
	input  wire logic                   RST,            // Sync reset, high
	input  wire logic                   HOST_MODE,      // Mode strap
	input  wire logic [1:0]             RATE_SEL,       // Rate straps
	input  wire logic                   LINE_BUILDOUT_BYPASS, // Strap
	input  wire logic                   RECEIVER_ON,    // Rx on / data
	input  wire logic                   RX_EQUALIZER_ENABLE, // Eq strap
	input  wire logic                   RX_CLOCK_INVERT, // Inv / select
	input  wire logic                   SINGLE_RAIL_SEL, // Rail strap
	input  wire logic                   LINE_CLOCK,     // Recovered clock
	input  wire logic                   LINE_POS,       // Positive pulse
	input  wire logic                   LINE_NEG,       // Negative pulse
	input  wire logic                   LINE_CODE_VIOLATION, // Violation
	input  wire logic [`LRX_ADDR_W-1:0] ADDR,           // Register address
	input  wire logic [`LRX_DATA_W-1:0] WDATA,          // Write data
	input  wire logic                   WR,             // Write strobe
	input  wire logic                   RD,             // Read strobe
	output logic      [`LRX_DATA_W-1:0] RDATA,          // Read data
	output logic                        BUILDOUT_ENABLE, // Build-out on
	output logic                        EQUALIZER_ACTIVE, // Eq in path
	output logic                        RECEIVER_ENABLE, // Receiver on
	output logic                        RECOVERED_CLOCK_OUT, // Rx clock
	output logic                        RX_POSITIVE_DATA, // Rx pos data
	output logic                        RX_NEGATIVE_DATA, // Rx neg data
	output logic                        HOST_SERIAL_IN, // Host data in
	output logic                        HOST_CHIP_SELECT, // Host select
	output logic                        IRQ             // Interrupt
);

	////////////////////////////////////////////////////////////////////
	// Functions

	// Build-out strap only has meaning at DS3 or STS-1 rate
	function automatic logic rate_uses_buildout(input logic [1:0] r);
		rate_uses_buildout = (r == LRX_RATE_DS3) || (r == LRX_RATE_STS1);
	endfunction : rate_uses_buildout

	// Register read decode; unmapped offsets read as zero
	function automatic logic [`LRX_DATA_W-1:0] read_word(
		input logic [`LRX_ADDR_W-1:0] a,
		input logic [`LRX_CTRL_W-1:0] c,
		input logic [`LRX_EVT_W-1:0]  s,
		input logic [`LRX_EVT_W-1:0]  m,
		input logic [`LRX_EFF_W-1:0]  e
	);
		read_word = '0;
		case (a)
			`LRX_OFF_CTRL:   read_word[`LRX_CTRL_W-1:0] = c;
			`LRX_OFF_STATUS: read_word[`LRX_EVT_W-1:0]  = s;
			`LRX_OFF_MASK:   read_word[`LRX_EVT_W-1:0]  = m;
			`LRX_OFF_EFFECT: read_word[`LRX_EFF_W-1:0]  = e;
			default:         read_word = '0;
		endcase
	endfunction : read_word

	////////////////////////////////////////////////////////////////////
	// Pin synchronisation

	lrx_pins_t pins_raw;
	lrx_pins_t s;

	// Gather every asynchronous pin into one carrier
	always_comb begin
		pins_raw.host   = HOST_MODE;
		pins_raw.rate   = RATE_SEL;
		pins_raw.bypass = LINE_BUILDOUT_BYPASS;
		pins_raw.rx_on  = RECEIVER_ON;
		pins_raw.eq     = RX_EQUALIZER_ENABLE;
		pins_raw.inv    = RX_CLOCK_INVERT;
		pins_raw.single = SINGLE_RAIL_SEL;
		pins_raw.lclk   = LINE_CLOCK;
		pins_raw.pos    = LINE_POS;
		pins_raw.neg    = LINE_NEG;
		pins_raw.viol   = LINE_CODE_VIOLATION;
	end

	lrx_sync #(
		.W ($bits(lrx_pins_t))
	) u_sync (
		.clk (REF_CLK),
		.d   (pins_raw),
		.q   (s)
	);

	////////////////////////////////////////////////////////////////////
	// Static mode selection

	logic       host_mode;
	logic [1:0] rate;
	logic       rst_q;
	logic       next_host_mode;
	logic [1:0] next_rate;
	logic       next_rst_q;

	// Caught while reset is held, frozen afterwards so pins never flip
	always_comb begin
		next_host_mode = RST ? s.host : host_mode;
		next_rate      = RST ? s.rate : rate;
		next_rst_q     = RST;
	end

	always_ff @(posedge REF_CLK) begin
		host_mode <= next_host_mode;
		rate      <= next_rate;
		rst_q     <= next_rst_q;
	end

	////////////////////////////////////////////////////////////////////
	// Registers and interrupt

	logic [`LRX_CTRL_W-1:0] ctrl;
	logic [`LRX_EVT_W-1:0]  status;
	logic [`LRX_EVT_W-1:0]  mask;
	logic [`LRX_CTRL_W-1:0] next_ctrl;
	logic [`LRX_EVT_W-1:0]  next_status;
	logic [`LRX_EVT_W-1:0]  next_mask;
	logic [`LRX_DATA_W-1:0] next_rdata;
	logic                   next_irq;
	logic [`LRX_EVT_W-1:0]  evt;
	logic [`LRX_EFF_W-1:0]  eff_word;
	lrx_cfg_t               cfg;
	logic                   next_buildout;

	// Write decode, sticky events; a new event beats a same-cycle clear
	always_comb begin
		next_ctrl   = ctrl;
		next_mask   = mask;
		next_status = status;
		if (WR && ADDR == `LRX_OFF_CTRL)
			next_ctrl = WDATA[`LRX_CTRL_W-1:0];
		if (WR && ADDR == `LRX_OFF_MASK)
			next_mask = WDATA[`LRX_EVT_W-1:0];
		if (WR && ADDR == `LRX_OFF_STATUS)
			next_status = status & ~WDATA[`LRX_EVT_W-1:0];
		next_status = next_status | evt;
		next_irq    = |(next_status & next_mask);
		next_rdata  = RD ? read_word(ADDR, ctrl, status, mask, eff_word)
		                 : '0;
		if (RST) begin
			next_ctrl   = `LRX_CTRL_RESET;
			next_mask   = `LRX_MASK_RESET;
			next_status = '0;
			next_irq    = 1'b0;
			next_rdata  = '0;
		end
	end

	always_ff @(posedge REF_CLK) begin
		ctrl   <= next_ctrl;
		mask   <= next_mask;
		status <= next_status;
		IRQ    <= next_irq;
		RDATA  <= next_rdata;
	end

	////////////////////////////////////////////////////////////////////
	// Shared pin muxing and line-side controls

	logic next_eq;
	logic next_rx_en;
	logic next_sdata;
	logic next_select;

	// Host mode takes settings from the control register, not pins
	always_comb begin
		cfg.rx_en   = host_mode ? ctrl[`LRX_CTRL_RX_EN]
		                        : s.rx_on;
		cfg.eq_en   = host_mode ? ctrl[`LRX_CTRL_EQ_EN]
		                        : s.eq;
		cfg.clk_inv = host_mode ? ctrl[`LRX_CTRL_CLK_INV]
		                        : s.inv;
		cfg.single  = host_mode ? ctrl[`LRX_CTRL_SINGLE] : s.single;
		// Bypass only when strapped in hardware mode at DS3 or STS-1
		next_buildout = !(!host_mode && rate_uses_buildout(rate)
		                  && s.bypass);
		next_eq     = cfg.eq_en;
		next_rx_en  = cfg.rx_en;
		next_sdata  = host_mode & s.rx_on;
		next_select = host_mode & s.inv;
		eff_word    = {host_mode, rate, BUILDOUT_ENABLE, cfg.single,
		               cfg.clk_inv, cfg.eq_en, cfg.rx_en};
		if (RST) begin
			next_buildout = 1'b1;
			next_eq       = 1'b0;
			next_rx_en    = 1'b0;
			next_sdata    = 1'b0;
			next_select   = 1'b0;
		end
	end

	always_ff @(posedge REF_CLK) begin
		BUILDOUT_ENABLE  <= next_buildout;
		EQUALIZER_ACTIVE <= next_eq;
		RECEIVER_ENABLE  <= next_rx_en;
		HOST_SERIAL_IN   <= next_sdata;
		HOST_CHIP_SELECT <= next_select;
	end

	////////////////////////////////////////////////////////////////////
	// Receive clock and data output

	logic lclk_q;
	logic line_rise;
	logic next_lclk_q;
	logic next_clk_out;
	logic next_pos;
	logic next_neg;

	// Data change on the line clock's rising edge; inverting the clock
	// out then places that change on its falling edge, as asked
	always_comb begin
		line_rise    = s.lclk & ~lclk_q;
		next_lclk_q  = s.lclk;
		next_clk_out = cfg.rx_en & (s.lclk ^ cfg.clk_inv);
		next_pos     = RX_POSITIVE_DATA;
		next_neg     = RX_NEGATIVE_DATA;
		evt          = '0;
		if (line_rise) begin
			next_pos = cfg.rx_en & s.pos;
			next_neg = cfg.rx_en & (cfg.single ? s.viol
			                                   : s.neg);
			evt[`LRX_EVT_POS]  = cfg.rx_en & s.pos;
			evt[`LRX_EVT_NEG]  = cfg.rx_en & ~cfg.single & s.neg;
			evt[`LRX_EVT_VIOL] = cfg.rx_en & cfg.single & s.viol;
		end
		if (!cfg.rx_en) begin
			next_pos = 1'b0;
			next_neg = 1'b0;
		end
		if (RST) begin
			next_lclk_q  = 1'b0;
			next_clk_out = 1'b0;
			next_pos     = 1'b0;
			next_neg     = 1'b0;
			evt          = '0;
		end
	end

	always_ff @(posedge REF_CLK) begin
		lclk_q              <= next_lclk_q;
		RECOVERED_CLOCK_OUT <= next_clk_out;
		RX_POSITIVE_DATA    <= next_pos;
		RX_NEGATIVE_DATA    <= next_neg;
	end

	////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST || rst_q); // Release edge still holds reset

	sequence seq_rise_on;
		line_rise && cfg.rx_en;
	endsequence

	sequence seq_ctrl_inv_write;
		WR && ADDR == `LRX_OFF_CTRL && WDATA[`LRX_CTRL_CLK_INV];
	endsequence

	property p_bypass;
		!host_mode && rate_uses_buildout(rate) && s.bypass
			|=> !BUILDOUT_ENABLE;
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("build-out not bypassed");

	property p_buildout_on;
		!s.bypass |=> BUILDOUT_ENABLE;
	endproperty
	a_buildout_on: assert property (p_buildout_on)
		else $error("build-out not enabled");

	property p_bypass_gated;
		(host_mode || !rate_uses_buildout(rate)) |=> BUILDOUT_ENABLE;
	endproperty
	a_bypass_gated: assert property (p_bypass_gated)
		else $error("bypass strap acted outside its mode");

	property p_rx_on_hw;
		!host_mode |=> RECEIVER_ENABLE == $past(s.rx_on);
	endproperty
	a_rx_on_hw: assert property (p_rx_on_hw)
		else $error("receiver enable does not follow pin");

	property p_host_pins;
		host_mode |=> HOST_SERIAL_IN == $past(s.rx_on)
			&& HOST_CHIP_SELECT == $past(s.inv)
			&& RECEIVER_ENABLE == $past(ctrl[`LRX_CTRL_RX_EN]);
	endproperty
	a_host_pins: assert property (p_host_pins)
		else $error("shared pins misrouted in host mode");

	property p_eq;
		1 |=> EQUALIZER_ACTIVE == (host_mode ?
			$past(ctrl[`LRX_CTRL_EQ_EN]) : $past(s.eq));
	endproperty
	a_eq: assert property (p_eq)
		else $error("equalizer setting wrong");

	property p_clk_out;
		cfg.rx_en |=> RECOVERED_CLOCK_OUT ==
			($past(s.lclk) ^ $past(cfg.clk_inv));
	endproperty
	a_clk_out: assert property (p_clk_out)
		else $error("recovered clock polarity wrong");

	property p_host_inv;
		host_mode && !RD ##0 seq_ctrl_inv_write ##1 !WR
			|=> cfg.clk_inv;
	endproperty
	a_host_inv: assert property (p_host_inv)
		else $error("control write did not invert clock");

	property p_pos_data;
		seq_rise_on |=> RX_POSITIVE_DATA == $past(s.pos)
			##1 (!line_rise || !cfg.rx_en) |-> $stable(RX_POSITIVE_DATA)
			|| !cfg.rx_en;
	endproperty
	a_pos_data: assert property (p_pos_data)
		else $error("positive data not captured at clock edge");

	property p_neg_data;
		seq_rise_on |=> RX_NEGATIVE_DATA ==
			($past(cfg.single) ? $past(s.viol) : $past(s.neg));
	endproperty
	a_neg_data: assert property (p_neg_data)
		else $error("negative output wrong for rail mode");

	property p_mode_static;
		1 |=> $stable(host_mode) && $stable(rate);
	endproperty
	a_mode_static: assert property (p_mode_static)
		else $error("mode selection changed after reset");

	property p_sticky;
		evt[`LRX_EVT_POS] ##1 !(WR && ADDR == `LRX_OFF_STATUS)
			|-> status[`LRX_EVT_POS] [*2];
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("positive event lost");

endmodule : lrx_rx_port

// >>> tb/lrx_line_model.sv
// Line-side source: recovered clock and detected pulse levels
`timescale 1ns/1ps
module lrx_line_model (
	input  wire logic run,   // Frame in progress
	input  wire logic pos,   // Positive pulse to send
	input  wire logic neg,   // Negative pulse to send
	input  wire logic viol,  // Violation to flag
	output logic      lclk,  // Recovered clock, still between frames
	output logic      lpos,  // Positive pulse level
	output logic      lneg,  // Negative pulse level
	output logic      lviol  // Violation level
);
////////////////////////////////////////////////////////////////////////
	// 400 ns bit period; data moves in the low phase, away from the rise
	initial begin
		lclk = 1'b0;
		lpos = 1'b0;
		lneg = 1'b0;
		lviol = 1'b0;
		// Offset keeps line edges away from the reference clock edge
		#10;
		forever begin
			if (run) begin
				lpos = pos;
				lneg = neg;
				lviol = viol;
				#200 lclk = 1'b1;
				#200 lclk = 1'b0;
			end else begin
				// Idle data toggles so stale levels never look valid
				lpos = ~lpos;
				lneg = ~lneg;
				lviol = ~lviol;
				#200;
			end
		end
	end
endmodule : lrx_line_model

// >>> tb/tb_top.sv
// Self-checking bench for the lrx receive port and strap control
`timescale 1ns/1ps
`include "lrx_defines.svh"
module tb_top
	import lrx_pkg::*;
;
	logic        clk, rst, host, bp, on, eq, inv, sr, wr, rd;
	logic [1:0]  rate;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata;
	logic        bo, eqa, rxe, co, rp, rn, hsi, hcs, irq;
	logic        run, mp, mn, mv, lclk, lpos, lneg, lviol;
	logic        sp, sn, sc, edge_bad;
	int          bad_count, tests_run;
	// Rows: {bypass, rx_on, eq, inv} then {buildout, eq, rx, clock out}
	logic [7:0]  rows [4] = '{8'he6, 8'h4a, 8'h5b, 8'h90};

	lrx_rx_port dut_u (.REF_CLK(clk), .RST(rst), .HOST_MODE(host),
		.RATE_SEL(rate), .LINE_BUILDOUT_BYPASS(bp), .RECEIVER_ON(on),
		.RX_EQUALIZER_ENABLE(eq), .RX_CLOCK_INVERT(inv),
		.SINGLE_RAIL_SEL(sr), .LINE_CLOCK(lclk), .LINE_POS(lpos),
		.LINE_NEG(lneg), .LINE_CODE_VIOLATION(lviol), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.BUILDOUT_ENABLE(bo), .EQUALIZER_ACTIVE(eqa),
		.RECEIVER_ENABLE(rxe), .RECOVERED_CLOCK_OUT(co),
		.RX_POSITIVE_DATA(rp), .RX_NEGATIVE_DATA(rn),
		.HOST_SERIAL_IN(hsi), .HOST_CHIP_SELECT(hcs), .IRQ(irq));
	lrx_line_model line_u (.run(run), .pos(mp), .neg(mn), .viol(mv),
		.lclk(lclk), .lpos(lpos), .lneg(lneg), .lviol(lviol));

	// 20 MHz reference clock
	always #25 clk = ~clk;
////////////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Verdict and end of run
	task automatic test_done;
		if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : test_done

	// Mode straps only count while reset is held
	task automatic reset(input logic h, input logic [1:0] r);
		host <= h;
		rate <= r;
		rst <= 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		#1 chk("rst_buildout", 1, bo);
		chk("rst_irq", 0, irq);
		@(posedge clk);
	endtask : reset

	// Register bus: one-cycle strobes, read data in the next cycle
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rdata", e, rdata);
		@(posedge clk);
	endtask : reg_rd

	// Frame of five bits; watches that data moves only with clock edge
	task automatic burst(input logic p, n, v, input logic iv);
		logic pc, pd, pn, ce;
		mp <= p;
		mn <= n;
		mv <= v;
		run <= 1'b1;
		{sp, sn, sc, edge_bad} = 4'h0;
		{pc, pd, pn} = {co, rp, rn};
		for (int i = 0; i < 40; i++) begin
			@(posedge clk);
			#1 ce = iv ? (pc & ~co) : (~pc & co);
			if ((rp !== pd || rn !== pn) && !ce) edge_bad = 1'b1;
			if (i >= 16 && rp === 1'b1) sp = 1'b1;
			if (i >= 16 && rn === 1'b1) sn = 1'b1;
			if (co !== pc) sc = 1'b1;
			{pc, pd, pn} = {co, rp, rn};
		end
		@(posedge clk);
		run <= 1'b0;
		repeat (24) @(posedge clk);
	endtask : burst

	// Cut a hang short
	initial begin
		repeat (100000) @(posedge clk);
		bad_count++;
		test_done();
	end
////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{clk, rst, host, bp, on, eq, inv, sr, wr, rd} = 10'h200;
		{run, mp, mn, mv} = 4'h0;
		{rate, addr, wdata} = 42'h0;
		rate = 2'h1;
		bad_count = 0;
		tests_run = 0;
		reset(1'b0, 2'h1);
		// Hardware mode straps, DS3
		foreach (rows[i]) begin
			{bp, on, eq, inv} <= rows[i][7:4];
			repeat (4) @(posedge clk);
			#1 chk("buildout", rows[i][3], bo);
			chk("equalizer", rows[i][2], eqa);
			chk("receiver", rows[i][1], rxe);
			chk("clock_out", rows[i][0], co);
			chk("host_serial", 0, hsi);
			@(posedge clk);
		end
		{bp, on, eq, inv} <= 4'h4;
		burst(1, 0, 0, 0);
		chk("pos_seen", 1, sp);
		chk("neg_seen", 0, sn);
		chk("clk_moved", 1, sc);
		chk("rise_edge", 0, edge_bad);
		burst(0, 1, 0, 0);
		chk("pos_seen", 0, sp);
		chk("neg_seen", 1, sn);
		inv <= 1'b1;
		burst(1, 1, 0, 1);
		chk("fall_edge", 0, edge_bad);
		chk("pos_seen", 1, sp);
		{on, inv} <= 2'h0;
		repeat (4) @(posedge clk);
		burst(1, 1, 1, 0);
		chk("off_pos", 0, sp);
		chk("off_clk", 0, sc);
		{on, sr} <= 2'h3;
		burst(0, 1, 0, 0);
		chk("lcv_neg", 0, sn);
		burst(0, 0, 1, 0);
		chk("lcv_flag", 1, sn);
		// E3 ignores the build-out strap
		bp <= 1'b1;
		reset(1'b0, 2'h0);
		repeat (4) @(posedge clk);
		#1 chk("e3_buildout", 1, bo);
		@(posedge clk);
		// Host mode: shared pins change function
		{bp, on, eq, inv, sr} <= 5'h16;
		@(posedge clk);
		reset(1'b1, 2'h1);
		repeat (3) @(posedge clk);
		#1 chk("host_buildout", 1, bo);
		chk("host_eq", 0, eqa);
		chk("host_rx", 1, rxe);
		chk("chip_sel", 1, hcs);
		chk("no_invert", 0, co);
		@(posedge clk);
		on <= 1'b1;
		repeat (4) @(posedge clk);
		#1 chk("serial_in", 1, hsi);
		@(posedge clk);
		reg_rd(`LRX_OFF_CTRL, 32'h1);
		reg_rd(`LRX_OFF_MASK, 32'h0);
		reg_rd(8'h10, 32'h0);
		reg_wr(`LRX_OFF_CTRL, 32'h7);
		repeat (3) @(posedge clk);
		#1 chk("sw_invert", 1, co);
		chk("sw_eq", 1, eqa);
		@(posedge clk);
		reg_wr(`LRX_OFF_CTRL, 32'h1);
		reg_wr(`LRX_OFF_MASK, 32'h1);
		burst(1, 0, 0, 0);
		chk("irq_set", 1, irq);
		reg_rd(`LRX_OFF_STATUS, 32'h1);
		reg_wr(`LRX_OFF_STATUS, 32'h1);
		#1 chk("irq_clear", 0, irq);
		@(posedge clk);
		reg_wr(`LRX_OFF_MASK, 32'h0);
		burst(0, 1, 0, 0);
		chk("irq_masked", 0, irq);
		reg_rd(`LRX_OFF_STATUS, 32'h2);
		reg_wr(`LRX_OFF_MASK, 32'h2);
		#1 chk("irq_unmask", 1, irq);
		@(posedge clk);
		reg_wr(`LRX_OFF_STATUS, 32'h7);
		reg_wr(`LRX_OFF_CTRL, 32'h9);
		burst(0, 0, 1, 0);
		chk("host_lcv", 1, sn);
		reg_rd(`LRX_OFF_STATUS, 32'h4);
		reg_rd(`LRX_OFF_EFFECT, 32'hb9);
		test_done();
	end
endmodule : tb_top
